// ===== design/cic_pkg.sv
// Constants and types for the CIC interpolation chain
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// [RULE1] I and Q streams pass through two cascaded CIC interpolators.
// [RULE2] Chain is fifth-order interpolator, second-order resampler, shared gain scaler.
// [RULE3] Combined shift is unsigned, 4 through 32, covering both stages.
// [RULE4] Net gain is L5 to the fourth times L2 times two to minus shift.
// [RULE5] Fifth-order factor minus one sits at channel offset 9.
// [RULE6] Software keeps fifth-order factor within 1 to 32 despite 8-bit field.
// [RULE7] Fifth-order stage emits L5 samples per input sample.
// [RULE8] Fifth-order stage is moving sum of length L5, raised to fifth power.
// [RULE9] Combined shift per channel sits at channel offset 6.
// [RULE10] Shift picks the output bit window, 6 dB per step.
// [RULE11] Software picks shift at least ceil(4 log2 L5 + log2 L2), smallest such.
// [RULE12] Resampler runs at output rate only, interpolates by L, decimates by M.
// [RULE13] Resampler supports non-integer ratios; rate change is L over M.
// [RULE14] Scaler compensates gain only in power-of-two steps.
// [RULE15] Resampler interpolation factor spans 1 to 4096 in twelve bits.
// [RULE16] Resampler decimation factor spans 1 to 512 in nine bits.
// [RULE17] Decimation and interpolation minus one sit at offsets 7 and 8.
// [RULE18] Both resampler factors at one pass samples straight through.
// [RULE19] I and Q share one sequencer and one set of factors.
// [RULE20] Final integrator is arithmetically shifted right, then truncated.
//////////////////////////////////////////////////////////////////////////////
package cic_pkg;
  localparam int IN_W   = 18;
  localparam int OUT_W  = 18;
  localparam int ACC_W  = 56;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 16;
  localparam logic [7:0]  OFS_SCALE  = 8'h06;
  localparam logic [7:0]  OFS_M2     = 8'h07;
  localparam logic [7:0]  OFS_L2     = 8'h08;
  localparam logic [7:0]  OFS_L5     = 8'h09;
  localparam logic [7:0]  OFS_STATUS = 8'h0A;
  localparam logic [5:0]  SCALE_MIN  = 6'h04;
  localparam logic [5:0]  SCALE_MAX  = 6'h20;
  localparam logic [5:0]  SCALE_RST  = 6'h04;
  localparam logic [7:0]  L5M1_RST   = 8'h00;
  localparam logic [8:0]  M2M1_RST   = 9'h000;
  localparam logic [11:0] L2M1_RST   = 12'h000;
  localparam int STAT_RUN   = 0;
  localparam int STAT_UNDER = 1;

  typedef enum logic [1:0] {
    CIC_PRIME = 2'b01,
    CIC_RUN   = 2'b10
  } cic_fsm_t;

  typedef struct packed {
    logic signed [IN_W-1:0] i;
    logic signed [IN_W-1:0] q;
  } cic_iq_t;

  typedef struct packed {
    logic [4:0][ACC_W-1:0] cd;
    logic [4:0][ACC_W-1:0] ig;
    logic [1:0][ACC_W-1:0] rd;
    logic [ACC_W-1:0]      h1;
    logic [ACC_W-1:0]      h2;
  } cic_path_t;

  typedef struct packed {
    cic_fsm_t              fsm;
    logic [5:0]            scale;
    logic [7:0]            l5m1;
    logic [8:0]            m2m1;
    logic [11:0]           l2m1;
    logic [7:0]            ph5;
    logic [11:0]           ph2;
    logic                  have_in;
    cic_iq_t               hold;
    logic [1:0][$bits(cic_path_t)-1:0] path;
    logic                  in_ready;
    logic                  out_valid;
    cic_iq_t               out;
    logic [DATA_W-1:0]     rdata;
    logic                  underrun;
  } cic_state_t;
endpackage

// ===== design/cic_interp_chain.sv
// Per-channel FIFTH_ORDER_INTERP_STAGE plus resampling CIC2 interpolation chain with shared scaler
`timescale 1ns/1ns
module cic_interp_chain #(
  parameter logic [3:0] CHANNEL = 4'h0
) (
  input  wire logic                           i_clk,
  input  wire logic                           i_rst,
  input  wire logic [cic_pkg::ADDR_W-1:0]     i_addr,
  input  wire logic [cic_pkg::DATA_W-1:0]     i_wdata,
  input  wire logic                           i_wr,
  input  wire logic                           i_rd,
  output logic      [cic_pkg::DATA_W-1:0]     o_rdata,
  input  wire logic                           i_in_valid,
  input  wire cic_pkg::cic_iq_t               i_in,
  output logic                                o_in_ready,
  input  wire logic                           i_out_req,
  output logic                                o_out_valid,
  output cic_pkg::cic_iq_t                    o_out
);

  localparam int AW = cic_pkg::ACC_W;

  function automatic logic addr_hit(input logic [cic_pkg::ADDR_W-1:0] a,
                                    input logic [7:0] ofs);
    addr_hit = (a[11:8] == CHANNEL) && (a[7:0] == ofs);
  endfunction

  cic_pkg::cic_state_t r;
  cic_pkg::cic_state_t n;
  cic_pkg::cic_path_t  pc;
  cic_pkg::cic_path_t  pn;
  logic [11:0]         room;
  logic [11:0]         m_fac;
  logic [11:0]         old_n;
  logic [11:0]         new_n;
  logic                can5;
  logic                active;
  logic                step;
  logic                rate_wr;
  logic [AW-1:0]       x;
  logic [AW-1:0]       c;
  logic [AW-1:0]       t;
  logic [AW-1:0]       acc;
  logic [AW-1:0]       h1n;
  logic signed [AW-1:0] sh;

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    n       = r;
    pc      = '0;
    pn      = '0;
    x       = '0;
    c       = '0;
    t       = '0;
    acc     = '0;
    h1n     = '0;
    sh      = '0;
    n.rdata = '0;
    n.out_valid = 1'b0;
    rate_wr = i_wr && (addr_hit(i_addr, cic_pkg::OFS_M2) ||
                       addr_hit(i_addr, cic_pkg::OFS_L2) ||
                       addr_hit(i_addr, cic_pkg::OFS_L5));

    // Register writes
    if (i_wr && addr_hit(i_addr, cic_pkg::OFS_SCALE)) begin
      // Out-of-range shifts saturate rather than overflow the window
      if (i_wdata[5:0] < cic_pkg::SCALE_MIN) begin
        n.scale = cic_pkg::SCALE_MIN; // [RULE3]
      end else if (i_wdata[5:0] > cic_pkg::SCALE_MAX) begin
        n.scale = cic_pkg::SCALE_MAX; // [RULE3]
      end else begin
        n.scale = i_wdata[5:0]; // [RULE9]
      end
    end
    if (i_wr && addr_hit(i_addr, cic_pkg::OFS_M2)) begin
      n.m2m1 = i_wdata[8:0]; // [RULE16]
    end
    if (i_wr && addr_hit(i_addr, cic_pkg::OFS_L2)) begin
      n.l2m1 = i_wdata[11:0]; // [RULE15]
    end
    if (i_wr && addr_hit(i_addr, cic_pkg::OFS_L5)) begin
      n.l5m1 = i_wdata[7:0]; // [RULE5]
    end
    if (i_wr && addr_hit(i_addr, cic_pkg::OFS_STATUS) && i_wdata[cic_pkg::STAT_UNDER]) begin
      n.underrun = 1'b0;
    end

    // Register reads, data valid the cycle after the strobe only
    if (i_rd) begin
      if (addr_hit(i_addr, cic_pkg::OFS_SCALE)) begin
        n.rdata = {10'h000, r.scale};
      end else if (addr_hit(i_addr, cic_pkg::OFS_M2)) begin
        n.rdata = {7'h00, r.m2m1}; // [RULE17]
      end else if (addr_hit(i_addr, cic_pkg::OFS_L2)) begin
        n.rdata = {4'h0, r.l2m1}; // [RULE17]
      end else if (addr_hit(i_addr, cic_pkg::OFS_L5)) begin
        n.rdata = {8'h00, r.l5m1};
      end else if (addr_hit(i_addr, cic_pkg::OFS_STATUS)) begin
        n.rdata = {14'h0000, r.underrun, r.fsm == cic_pkg::CIC_RUN};
      end
    end

    // Input side: one held sample, refilled when the FIFTH_ORDER_INTERP_STAGE takes it
    if (r.in_ready && i_in_valid) begin
      n.have_in = 1'b1;
      n.hold    = i_in;
      n.fsm     = cic_pkg::CIC_RUN;
    end

    // Resampler bookkeeping: M ticks of the virtual L-rate grid per output.
    // Only one input boundary can fall inside a step while M is at most L, so no fast clock.
    room   = r.l2m1 - r.ph2;
    m_fac  = {3'h0, r.m2m1} + 12'h001;
    old_n  = (m_fac <= room) ? m_fac : room; // [RULE12]
    new_n  = m_fac - old_n; // [RULE13]
    can5   = (r.ph5 != 8'h00) || r.have_in;
    active = i_out_req && (r.fsm == cic_pkg::CIC_RUN);
    step   = active && ((new_n == 12'h000) || can5);
    if (active && !step) begin
      n.underrun = 1'b1;
    end

    if (step) begin
      n.out_valid = 1'b1;
      // Same phase counters drive both paths to keep I and Q aligned
      for (int p = 0; p < 2; p++) begin // [RULE19]
        pc = r.path[p];
        pn = pc;
        if (new_n != 12'h000) begin
          // FIFTH_ORDER_INTERP_STAGE tick: combs run only on the stuffed input sample
          x = (p == 0) ? AW'(r.hold.i) : AW'(r.hold.q);
          acc = '0;
          if (r.ph5 == 8'h00) begin
            c = x;
            for (int k = 0; k < 5; k++) begin // [RULE8]
              t = c - pc.cd[k];
              pn.cd[k] = c;
              c = t;
            end
            acc = c; // [RULE7]
          end
          for (int k = 0; k < 5; k++) begin // [RULE8]
            pn.ig[k] = pc.ig[k] + acc;
            acc = pn.ig[k];
          end
          // Resampler combs at its input rate, then zero-stuffed integrators
          c = acc; // [RULE1]
          for (int k = 0; k < 2; k++) begin
            t = c - pc.rd[k];
            pn.rd[k] = c;
            c = t;
          end
          h1n = pc.h1 + c;
          pn.h1 = h1n;
          pn.h2 = pc.h2 + AW'(pc.h1 * old_n) + AW'(h1n * new_n); // [RULE13]
        end else begin
          pn.h2 = pc.h2 + AW'(pc.h1 * m_fac); // [RULE12]
        end
        // Power-of-two gain trim only; finer trim lives upstream
        sh = $signed(pn.h2) >>> r.scale; // [RULE20] [RULE14] [RULE4]
        if (p == 0) begin
          n.out.i = sh[cic_pkg::OUT_W-1:0]; // [RULE10]
        end else begin
          n.out.q = sh[cic_pkg::OUT_W-1:0]; // [RULE10]
        end
        n.path[p] = pn; // [RULE2]
      end
      if (new_n != 12'h000) begin
        n.ph2 = new_n - 12'h001; // [RULE18]
        n.ph5 = (r.ph5 == r.l5m1) ? 8'h00 : r.ph5 + 8'h01; // [RULE7]
        if (r.ph5 == 8'h00) begin
          n.have_in = 1'b0;
        end
      end else begin
        n.ph2 = r.ph2 + m_fac;
      end
    end

    // A rate change mid-stream would corrupt the integrators: restart
    if (rate_wr) begin
      n.fsm     = cic_pkg::CIC_PRIME;
      n.path    = '0;
      n.ph5     = 8'h00;
      n.ph2     = n.l2m1;
      n.have_in = 1'b0;
      n.out_valid = 1'b0;
    end

    n.in_ready = !n.have_in;
  end

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      r          <= '0;
      r.fsm      <= cic_pkg::CIC_PRIME;
      r.scale    <= cic_pkg::SCALE_RST;
      r.l5m1     <= cic_pkg::L5M1_RST;
      r.m2m1     <= cic_pkg::M2M1_RST;
      r.l2m1     <= cic_pkg::L2M1_RST;
      r.ph2      <= cic_pkg::L2M1_RST;
      r.in_ready <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign o_rdata     = r.rdata;
  assign o_in_ready  = r.in_ready;
  assign o_out_valid = r.out_valid;
  assign o_out       = r.out;

  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  AST_SCALE_RANGE: assert property ( // [RULE3]
    r.scale >= cic_pkg::SCALE_MIN && r.scale <= cic_pkg::SCALE_MAX)
    else $error("shift setting left the 4 to 32 range");

  AST_L5_READBACK: assert property ( // [RULE5]
    (i_wr && addr_hit(i_addr, cic_pkg::OFS_L5)) ##1
    (i_rd && addr_hit(i_addr, cic_pkg::OFS_L5)) |=>
    o_rdata == {8'h00, $past(i_wdata[7:0], 2)})
    else $error("fifth-order factor readback mismatch");

  AST_M2_READBACK: assert property ( // [RULE16]
    (i_wr && addr_hit(i_addr, cic_pkg::OFS_M2)) ##1
    (i_rd && addr_hit(i_addr, cic_pkg::OFS_M2)) |=>
    o_rdata == {7'h00, $past(i_wdata[8:0], 2)})
    else $error("decimation factor readback mismatch");

  AST_L2_READBACK: assert property ( // [RULE15]
    (i_wr && addr_hit(i_addr, cic_pkg::OFS_L2)) ##1
    (i_rd && addr_hit(i_addr, cic_pkg::OFS_L2)) |=>
    o_rdata == {4'h0, $past(i_wdata[11:0], 2)})
    else $error("interpolation factor readback mismatch");

  AST_OUT_ON_REQ: assert property ( // [RULE12]
    o_out_valid |-> $past(i_out_req) && $past(r.fsm) == cic_pkg::CIC_RUN)
    else $error("output produced without a request");

  AST_PH5_BOUND: assert property ( // [RULE7]
    r.fsm == cic_pkg::CIC_RUN |-> r.ph5 <= r.l5m1)
    else $error("fifth-order phase beyond factor");

  AST_FLUSH: assert property ( // [RULE17]
    rate_wr |=> r.fsm == cic_pkg::CIC_PRIME && o_in_ready && !o_out_valid)
    else $error("rate write did not restart the chain");

  AST_IN_ONCE: assert property ( // [RULE1]
    i_in_valid && o_in_ready && !rate_wr |=> !o_in_ready [*1] ##0 r.have_in)
    else $error("accepted sample not held");

  AST_BYPASS: assert property ( // [RULE18]
    step && r.l2m1 == 12'h000 && r.m2m1 == 9'h000 |-> new_n == 12'h001)
    else $error("unity resampler did not consume one sample per output");

  AST_STARVE: assert property ( // [RULE13]
    active && new_n != 12'h000 && !can5 && !rate_wr |=> r.underrun && !o_out_valid)
    else $error("starved request not flagged");

  COV_BYPASS: cover property (o_out_valid && r.l2m1 == 12'h000 && r.m2m1 == 9'h000);
  COV_FRACT:  cover property (step && new_n == 12'h000);
  COV_UNDER:  cover property (active && !step);
  COV_L5:     cover property (step && r.l5m1 != 8'h00 && r.ph5 == r.l5m1);

endmodule

// ===== dv/cic_partner.sv
// Upstream sample source and downstream request pacer for the CIC chain
`timescale 1ns/1ns
module cic_partner (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_src_en,
  input  wire cic_pkg::cic_iq_t i_sample,
  input  wire logic             i_ready,
  input  wire logic             i_req_en,
  output logic                  o_valid,
  output cic_pkg::cic_iq_t      o_data,
  output logic                  o_req
);
  logic [1:0] pace;
  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_valid <= 1'b0;
      o_data  <= '0;
      o_req   <= 1'b0;
      pace    <= 2'h0;
    end else begin
      // Held until taken; idle data toggles so a stale word never matches
      if (!o_valid || i_ready) begin
        o_valid <= i_src_en;
        o_data  <= i_src_en ? i_sample : ~o_data;
      end
      pace  <= pace + 2'h1;
      o_req <= i_req_en && (pace == 2'h3);
    end
  end
endmodule

// ===== dv/cic_interpolation_chain_test.sv
// Self-checking bench for the CIC interpolation chain
`timescale 1ns/1ns
module cic_interpolation_chain_test;
  int                         err_count, compares, outs, takes, n, g, d, xi, xq;
  logic [11:0]                i_addr;
  logic [15:0]                i_wdata, o_rdata, rd_val;
  logic                       i_clk, i_rst, i_wr, i_rd, i_in_valid, i_out_req;
  logic                       o_in_ready, o_out_valid, src_en, req_en;
  cic_pkg::cic_iq_t           i_in, o_out, sample, last;
  logic [17:0]                ei, eq;
  bit                         live;
  // L5, L2, M, shift; shifts are the smallest legal ones except row 1
  int cfg [6][4] = '{'{1,1,1,4}, '{1,1,1,9}, '{2,1,1,4}, '{3,1,1,7}, '{2,2,1,5}, '{4,3,2,10}};
  int rt [8][4] = '{'{'h009,'hFFFF,'h009,'hFF}, '{'h008,'hFFFF,'h008,'hFFF},
    '{'h007,'hFFFF,'h007,'h1FF}, '{'h006,'h2,'h006,'h4}, '{'h006,'h28,'h006,'h20},
    '{'h006,'h11,'h006,'h11}, '{'h109,'h7,'h009,'hFF}, '{'h00B,'hFFFF,'h00B,'h0}};
  int ra [7] = '{'h006, 'h007, 'h008, 'h009, 'h00A, 'h00B, 'h106};
  //////////////////////////////////////////////////////////////////////////////
  cic_interp_chain u_cic_interp_chain (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_in_valid(i_in_valid),
    .i_in(i_in), .o_in_ready(o_in_ready), .i_out_req(i_out_req), .o_out_valid(o_out_valid),
    .o_out(o_out));
  cic_partner u_cic_partner (.i_clk(i_clk), .i_rst(i_rst), .i_src_en(src_en),
    .i_sample(sample), .i_ready(o_in_ready), .i_req_en(req_en), .o_valid(i_in_valid),
    .o_data(i_in), .o_req(i_out_req));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [17:0] seen, input logic [17:0] expv);
    compares++;
    if (seen !== expv) begin
      err_count++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, expv);
    end
  endtask
  task automatic wr(input int a, input int dt);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= 12'(a);
    i_wdata <= 16'(dt);
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input int a);
    i_rd   <= 1'b1;
    i_addr <= 12'(a);
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(posedge i_clk);
    rd_val = o_rdata;
  endtask
  task automatic run(input int cyc);
    @(posedge i_clk);
    req_en <= 1'b1;
    repeat (cyc) @(posedge i_clk);
    req_en <= 1'b0;
    repeat (8) @(posedge i_clk);
  endtask
  task automatic end_sim;
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    if (o_out_valid === 1'b1) begin
      outs++;
      last <= o_out;
      // Early outputs still carry the step response, so only settled ones are exact
      if (live && outs > 64) begin
        chk(o_out.i, ei);
        chk(o_out.q, eq);
      end
    end
    if (i_in_valid && o_in_ready) takes++;
  end
  initial begin
    #500000;
    err_count++;
    end_sim();
  end
  initial begin
    {i_rst, i_wr, i_rd, i_addr, i_wdata, src_en, req_en, sample} = '0;
    i_rst = 1'b1;
    void'($urandom(32'h08B1CDEC));
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    foreach (ra[k]) begin
      rd(ra[k]);
      chk(18'(rd_val), (k == 0) ? 18'h4 : 18'h0);
    end
    foreach (rt[k]) begin
      wr(rt[k][0], rt[k][1]);
      rd(rt[k][2]);
      chk(18'(rd_val), 18'(rt[k][3]));
    end
    $display("register test done");
    foreach (cfg[k]) begin
      wr('h006, cfg[k][3]);
      wr('h007, cfg[k][2] - 1);
      wr('h008, cfg[k][1] - 1);
      wr('h009, cfg[k][0] - 1);
      xi = int'($urandom_range(8191)) - 4096;
      xq = int'($urandom_range(8191)) - 4096;
      g = cfg[k][0] ** 4 * cfg[k][1];
      ei = 18'((longint'(xi) * g) >>> cfg[k][3]);
      eq = 18'((longint'(xq) * g) >>> cfg[k][3]);
      @(posedge i_clk);
      sample <= {18'(xi), 18'(xq)};
      src_en <= 1'b1;
      outs = 0;
      takes = 0;
      live = 1'b1;
      run(1200);
      live = 1'b0;
      chk(last.i, ei);
      chk(last.q, eq);
      d = outs * cfg[k][2] - takes * cfg[k][0] * cfg[k][1];
      chk(18'(d <= 2 * g && d >= -2 * g && outs > 100), 18'h1);
      rd('h00A);
      chk(18'(rd_val), 18'h1);
      @(posedge i_clk);
      src_en <= 1'b0;
      $display("stream test %0d done", k);
    end
    run(200);
    rd('h00A);
    chk(18'(rd_val), 18'h3);
    wr('h00A, 'h2);
    rd('h00A);
    chk(18'(rd_val), 18'h1);
    wr('h009, 'h0);
    n = outs;
    run(40);
    rd('h00A);
    chk(18'(rd_val), 18'h0);
    chk(18'(outs - n), 18'h0);
    $display("underrun test done");
    end_sim();
  end
endmodule
